/* File: rtl/nor_program_erase_sequencer.v */
// Notes on behaviour
// - Opcodes 02h, A2h, D2h decode as single, dual, extended dual programs.
// - Opcodes 32h and 38h decode as quad and extended quad programs.
// - Programming only clears bits; a zero bit stays zero.
// - Write-in-progress is 1 during a program, 0 after it.
// - Write-enable latch clears at the end of each program or erase.
// - Data past page end wraps to the start of the same page.
// - More than a page of bytes keeps only the last page of bytes.
// - Short programs change only addressed bytes of the page.
// - Program, subsector and sector erase can suspend and resume.
// - Erase sets every bit of the region to 1.
// - Erase without write-enable is ignored with no error flag.
// - Select must rise after a whole byte, else nothing executes.
// - Erase of a protected subsector skips, keeps latch, sets flags 1 and 5.
// - During erase controller-ready is 0 and write-in-progress is 1.
// - Erase timeout resets the latch and sets the erase error flag.
// - Controller-ready returns to 1 when an erase finishes.
// - 52h or 20h subsector erase, D8h sector erase, region to FFh.
// - Erase accepts any address in the region, bits sampled on rising clock.
// - C7h or 60h bulk erase sets the whole die to FFh.
// - Bulk erase with any sector locked refuses, sets flags 1 and 5.
// - Last address bit at count 7+AW, 7+AW/2 or 7+AW/4 by width.
// - Operations run self-timed for the time fitting the opcode.
// - Program without the write-enable latch does not start.
// - Program to a protected sector skips, keeps latch, sets flags 1 and 4.
// - Program timeout resets the latch and sets the program error flag.
`include "nor_seq_map.vh"
module nor_program_erase_sequencer #(
  parameter ADDR_W      = 24,
  parameter PAGE_BYTES  = 256,
  parameter PAGE_AW     = 8,
  parameter SUBSECT_AW  = 12,
  parameter SECT_AW     = 16,
  parameter [31:0] PP_CYCLES  = `PP_CYCLES,
  parameter [31:0] SSE_CYCLES = `SSE_CYCLES,
  parameter [31:0] SE_CYCLES  = `SE_CYCLES,
  parameter [31:0] BE_CYCLES  = `BE_CYCLES
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              sel_n,
  input  wire              sclk,
  input  wire [3:0]        serial_data_lines,
  input  wire              set_write_enable,
  input  wire              clear_flags,
  input  wire              target_protected,
  input  wire              any_sector_locked,
  input  wire              op_timeout,
  output reg               write_in_progress,
  output reg               write_enable_latch,
  output reg  [7:0]        flag_status,
  output reg               mem_wr,
  output reg  [ADDR_W-1:0] mem_addr,
  output reg  [7:0]        mem_wdata,
  input  wire [7:0]        mem_rdata,
  output reg               erase_start,
  output reg  [1:0]        erase_kind,
  output reg  [ADDR_W-1:0] erase_base
);
  // ===================================================
  // Pin synchronisation
  wire [5:0] pins_s;
  sync2 #(.W(6)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({sel_n, sclk, serial_data_lines}),
    .q   (pins_s)
  );
  wire       sel_n_s = pins_s[5];
  wire       sclk_s  = pins_s[4];
  wire [3:0] dq_s    = pins_s[3:0];
  reg        sclk_d;
  reg        sel_n_d;
  wire       rise     = sclk_s & ~sclk_d & ~sel_n_s;
  wire       sel_rise = sel_n_s & ~sel_n_d;

  // ===================================================
  // Command shifter
  localparam OP_NONE = 3'd0, OP_PROG = 3'd1, OP_SSE = 3'd2, OP_SE = 3'd3, OP_BE = 3'd4;
  localparam OP_SUS = 3'd5, OP_RES = 3'd6;
  reg  [7:0]        opcode;
  reg  [2:0]        op_kind;
  reg  [2:0]        addr_lanes;   // Bits per edge during address
  reg  [2:0]        data_lanes;   // Bits per edge during data
  reg  [5:0]        bit_cnt;      // Bits taken in the current phase
  reg  [1:0]        phase;        // 0 opcode 1 address 2 data
  reg  [ADDR_W-1:0] addr;
  reg  [7:0]        shreg;
  reg  [PAGE_AW-1:0] wr_idx;
  reg               byte_done;    // Stream ended on a byte edge
  reg               any_data;
  reg               pb_wr;
  reg  [7:0]        pb_data;
  reg  [PAGE_AW-1:0] pb_idx;

  wire [2:0] lanes = (phase == 2'd0) ? 3'd1 : (phase == 2'd1) ? addr_lanes : data_lanes;
  reg  [7:0] next_shreg;
  always @* begin
    case (lanes)
      3'd2:    next_shreg = {shreg[5:0], dq_s[1:0]};
      3'd4:    next_shreg = {shreg[3:0], dq_s};
      default: next_shreg = {shreg[6:0], dq_s[0]};
    endcase
  end
  wire [5:0] next_bits = bit_cnt + {3'd0, lanes};
  // Address including the bits of this edge, so the page offset sees the last ones too
  reg  [ADDR_W-1:0] next_addr;
  always @* begin
    case (lanes)
      3'd2:    next_addr = {addr[ADDR_W-3:0], dq_s[1:0]};
      3'd4:    next_addr = {addr[ADDR_W-5:0], dq_s};
      default: next_addr = {addr[ADDR_W-2:0], dq_s[0]};
    endcase
  end

  // ===================================================
  // Operation engine state
  localparam S_IDLE = 3'd0, S_CMD = 3'd1, S_PROG = 3'd2, S_ERASE = 3'd3, S_SUSP = 3'd4;
  reg  [2:0]  state;
  reg  [31:0] timer;
  reg  [31:0] duration;
  reg         is_prog;
  reg  [ADDR_W-1:0] op_addr;
  reg  [PAGE_AW:0]  scan;
  wire [7:0]  pb_rdata;
  wire        pb_valid;
  wire        pb_clear = (state == S_CMD) & ~sel_n_s & sel_n_d;

  page_buffer #(.PAGE_BYTES(PAGE_BYTES), .AW(PAGE_AW)) u_page (
    .clk      (clk),
    .rst      (rst),
    .clear    (pb_clear),
    .wr       (pb_wr),
    .wr_idx   (pb_idx),
    .wr_data  (pb_data),
    .rd_idx   (scan[PAGE_AW-1:0]),
    .rd_data  (pb_rdata),
    .rd_valid (pb_valid)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0; sel_n_d <= 1'b1;
      opcode <= 8'h00; op_kind <= OP_NONE; addr_lanes <= 3'd1; data_lanes <= 3'd1;
      bit_cnt <= 6'd0; phase <= 2'd0; addr <= {ADDR_W{1'b0}}; shreg <= 8'h00;
      wr_idx <= {PAGE_AW{1'b0}}; byte_done <= 1'b1; any_data <= 1'b0;
      pb_wr <= 1'b0; pb_data <= 8'h00; pb_idx <= {PAGE_AW{1'b0}};
    end else begin
      sclk_d  <= sclk_s;
      sel_n_d <= sel_n_s;
      pb_wr   <= 1'b0;
      if (~sel_n_s & sel_n_d) begin
        phase <= 2'd0; bit_cnt <= 6'd0; byte_done <= 1'b1; any_data <= 1'b0;
        op_kind <= OP_NONE;
      end else if (rise) begin
        shreg <= next_shreg;
        case (phase)
          2'd0: begin
            byte_done <= (next_bits == 6'd8);
            if (next_bits == 6'd8) begin
              bit_cnt <= 6'd0;
              opcode  <= next_shreg;
              phase   <= 2'd1;
              case (next_shreg)
                `OP_PAGE_PROG: begin op_kind <= OP_PROG; addr_lanes <= 3'd1; data_lanes <= 3'd1; end
                `OP_DUAL_PROG: begin op_kind <= OP_PROG; addr_lanes <= 3'd1; data_lanes <= 3'd2; end
                `OP_XDUAL_PROG: begin op_kind <= OP_PROG; addr_lanes <= 3'd2; data_lanes <= 3'd2; end
                `OP_QUAD_PROG: begin op_kind <= OP_PROG; addr_lanes <= 3'd1; data_lanes <= 3'd4; end
                `OP_XQUAD_PROG: begin op_kind <= OP_PROG; addr_lanes <= 3'd4; data_lanes <= 3'd4; end
                `OP_SUBSECT_ERASE, `OP_SUBSECT_ERASE2: begin op_kind <= OP_SSE; addr_lanes <= 3'd1; end
                `OP_SECT_ERASE: begin op_kind <= OP_SE; addr_lanes <= 3'd1; end
                `OP_BULK_ERASE, `OP_BULK_ERASE2: begin op_kind <= OP_BE; phase <= 2'd3; end
                `OP_SUSPEND: begin op_kind <= OP_SUS; phase <= 2'd3; end
                `OP_RESUME: begin op_kind <= OP_RES; phase <= 2'd3; end
                default: begin op_kind <= OP_NONE; phase <= 2'd3; end
              endcase
            end else begin
              bit_cnt <= next_bits;
            end
          end
          2'd1: begin
            // Address shifts in on rising edges, lane count per mode
            addr <= next_addr;
            byte_done <= (next_bits[2:0] == 3'd0);
            if (next_bits == ADDR_W) begin
              bit_cnt <= 6'd0;
              phase   <= (op_kind == OP_PROG) ? 2'd2 : 2'd3;
              wr_idx  <= next_addr[PAGE_AW-1:0];
              byte_done <= 1'b1;
            end else begin
              bit_cnt <= next_bits;
            end
          end
          2'd2: begin
            byte_done <= (next_bits == 6'd8);
            if (next_bits == 6'd8) begin
              bit_cnt  <= 6'd0;
              pb_wr    <= 1'b1;
              pb_idx   <= wr_idx;
              pb_data  <= next_shreg;
              wr_idx   <= wr_idx + 1'b1;  // Wraps inside the page
              any_data <= 1'b1;
            end else begin
              bit_cnt <= next_bits;
            end
          end
          default: byte_done <= 1'b0;  // Extra clocks after a complete command spoil it
        endcase
      end
    end
  end

  // ===================================================
  // Self-timed execution
  wire cmd_ok = byte_done & (phase == 2'd3 | (phase == 2'd2 & any_data));
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE; timer <= 32'd0; duration <= 32'd0; is_prog <= 1'b0;
      op_addr <= {ADDR_W{1'b0}}; scan <= {(PAGE_AW+1){1'b0}};
      write_in_progress <= 1'b0; write_enable_latch <= 1'b0; flag_status <= `FLAG_RESET;
      mem_wr <= 1'b0; mem_addr <= {ADDR_W{1'b0}}; mem_wdata <= 8'h00;
      erase_start <= 1'b0; erase_kind <= 2'd0; erase_base <= {ADDR_W{1'b0}};
    end else begin
      mem_wr      <= 1'b0;
      erase_start <= 1'b0;
      if (set_write_enable)
        write_enable_latch <= 1'b1;
      if (clear_flags)
        flag_status[`FL_PROT_ERR] <= 1'b0;
      if (clear_flags)
        flag_status[`FL_PROG_ERR] <= 1'b0;
      if (clear_flags)
        flag_status[`FL_ERASE_ERR] <= 1'b0;
      if (state == S_IDLE && sel_n_s)
        state <= S_CMD;
      case (state)
        S_CMD: begin
          if (sel_rise && cmd_ok && write_enable_latch) begin
            if (op_kind == OP_PROG) begin
              if (target_protected) begin
                flag_status[`FL_PROT_ERR] <= 1'b1;
                flag_status[`FL_PROG_ERR] <= 1'b1;
              end else begin
                is_prog <= 1'b1; duration <= PP_CYCLES; timer <= 32'd0;
                op_addr <= {addr[ADDR_W-1:PAGE_AW], {PAGE_AW{1'b0}}};
                scan <= {(PAGE_AW+1){1'b0}};
                write_in_progress <= 1'b1;
                flag_status[`FL_READY] <= 1'b0;
                state <= S_PROG;
              end
            end else if (op_kind == OP_SSE || op_kind == OP_SE || op_kind == OP_BE) begin
              if ((op_kind == OP_BE) ? any_sector_locked : target_protected) begin
                flag_status[`FL_PROT_ERR]  <= 1'b1;
                flag_status[`FL_ERASE_ERR] <= 1'b1;
              end else begin
                is_prog <= 1'b0; timer <= 32'd0;
                // Region base ignores low address bits
                case (op_kind)
                  OP_SSE: begin duration <= SSE_CYCLES;
                    erase_base <= {addr[ADDR_W-1:SUBSECT_AW], {SUBSECT_AW{1'b0}}}; end
                  OP_SE: begin duration <= SE_CYCLES;
                    erase_base <= {addr[ADDR_W-1:SECT_AW], {SECT_AW{1'b0}}}; end
                  default: begin duration <= BE_CYCLES; erase_base <= {ADDR_W{1'b0}}; end
                endcase
                erase_kind  <= op_kind[1:0];
                erase_start <= 1'b1;  // Array fills region with FFh
                write_in_progress <= 1'b1;
                flag_status[`FL_READY] <= 1'b0;
                state <= S_ERASE;
              end
            end
          end
        end
        S_PROG, S_ERASE: begin
          timer <= timer + 32'd1;
          // Program merges buffered bytes, AND keeps zeros at zero
          if (state == S_PROG && !scan[PAGE_AW] && timer[0]) begin
            if (pb_valid) begin
              mem_wr    <= 1'b1;
              mem_addr  <= op_addr | {{(ADDR_W-PAGE_AW){1'b0}}, scan[PAGE_AW-1:0]};
              mem_wdata <= pb_rdata & mem_rdata;
            end
            scan <= scan + 1'b1;
          end else if (state == S_PROG && !scan[PAGE_AW]) begin
            mem_addr <= op_addr | {{(ADDR_W-PAGE_AW){1'b0}}, scan[PAGE_AW-1:0]};
          end
          if (sel_rise && cmd_ok && op_kind == OP_SUS && (is_prog || erase_kind != 2'd0)) begin
            state <= S_SUSP;
            flag_status[`FL_READY] <= 1'b1;
            flag_status[is_prog ? `FL_PROG_SUSP : `FL_ERASE_SUSP] <= 1'b1;
          end else if (op_timeout) begin
            write_enable_latch <= 1'b0;
            flag_status[is_prog ? `FL_PROG_ERR : `FL_ERASE_ERR] <= 1'b1;
            write_in_progress <= 1'b0;
            flag_status[`FL_READY] <= 1'b1;
            state <= S_CMD;
          end else if (timer + 32'd1 >= duration && (!is_prog || scan[PAGE_AW])) begin
            write_in_progress <= 1'b0;
            write_enable_latch <= 1'b0;
            flag_status[`FL_READY] <= 1'b1;
            state <= S_CMD;
          end
        end
        S_SUSP: begin
          if (sel_rise && cmd_ok && op_kind == OP_RES) begin
            state <= is_prog ? S_PROG : S_ERASE;
            flag_status[`FL_READY] <= 1'b0;
            flag_status[`FL_PROG_SUSP]  <= 1'b0;
            flag_status[`FL_ERASE_SUSP] <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end
endmodule // nor_program_erase_sequencer

/* File: rtl/nor_seq_map.vh */
`ifndef NOR_SEQ_MAP_VH
`define NOR_SEQ_MAP_VH
// Opcodes
`define OP_PAGE_PROG      8'h02
`define OP_DUAL_PROG      8'ha2
`define OP_XDUAL_PROG     8'hd2
`define OP_QUAD_PROG      8'h32
`define OP_XQUAD_PROG     8'h38
`define OP_SUBSECT_ERASE  8'h52
`define OP_SUBSECT_ERASE2 8'h20
`define OP_SECT_ERASE     8'hd8
`define OP_BULK_ERASE     8'hc7
`define OP_BULK_ERASE2    8'h60
`define OP_SUSPEND        8'h75
`define OP_RESUME         8'h7a
`define ERASED_BYTE       8'hff
// Flag status bit positions
`define FL_READY          7
`define FL_ERASE_SUSP     6
`define FL_ERASE_ERR      5
`define FL_PROG_ERR       4
`define FL_PROG_SUSP      2
`define FL_PROT_ERR       1
`define FLAG_RESET        8'h80
// Self-timed durations in microseconds and their clock counts at 10 MHz
`define CLK_MHZ                   10
`define PAGE_PROGRAM_TIME_US      120
`define SUBSECTOR_ERASE_TIME_US   50000
`define SECTOR_ERASE_TIME_US      150000
`define BULK_ERASE_TIME_US        10000000
`define PP_CYCLES   (`PAGE_PROGRAM_TIME_US * `CLK_MHZ)
`define SSE_CYCLES  (`SUBSECTOR_ERASE_TIME_US * `CLK_MHZ)
`define SE_CYCLES   (`SECTOR_ERASE_TIME_US * `CLK_MHZ)
`define BE_CYCLES   (`BULK_ERASE_TIME_US * `CLK_MHZ)
`endif

/* File: rtl/sync2.v */
module sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sync2

/* File: rtl/page_buffer.v */
// ===================================================
// Page buffer: holds one page of incoming data with byte valid marks
module page_buffer #(
  parameter PAGE_BYTES = 256,
  parameter AW         = 8
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          clear,
  input  wire          wr,
  input  wire [AW-1:0] wr_idx,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] rd_idx,
  output wire [7:0]    rd_data,
  output wire          rd_valid
);
  reg [7:0] mem [0:PAGE_BYTES-1];
  reg [PAGE_BYTES-1:0] valid;
  genvar i;
  generate
    for (i = 0; i < PAGE_BYTES; i = i + 1) begin : g_ent
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          mem[i]   <= 8'h00;
          valid[i] <= 1'b0;
        end else if (clear) begin
          valid[i] <= 1'b0;
        end else if (wr && wr_idx == i) begin
          // Later bytes overwrite earlier ones at the same slot
          mem[i]   <= wr_data;
          valid[i] <= 1'b1;
        end
      end
    end
  endgenerate
  assign rd_data  = mem[rd_idx];
  assign rd_valid = valid[rd_idx];
endmodule // page_buffer

/* File: verif/nor_seq_checker_sva.sv */
// ==========================================
// Port-level checks of the program/erase sequencer
module nor_seq_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       op_timeout,
  input wire logic       write_in_progress,
  input wire logic       write_enable_latch,
  input wire logic [7:0] flag_status,
  input wire logic       mem_wr,
  input wire logic       erase_start,
  input wire logic [1:0] erase_kind
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence busy_s;
    write_in_progress && !flag_status[7];
  endsequence
  sequence done_s;
    !write_in_progress && !write_enable_latch;
  endsequence
  // Suspended operations are excluded: readiness is legal then
  a_busy_not_ready:
    assert property (write_in_progress && !flag_status[2] && !flag_status[6] |-> !flag_status[7])
    else $error("ready flag high while busy");
  a_end_clears_latch:
    assert property ($fell(write_in_progress) && !flag_status[2] && !flag_status[6]
      |-> !write_enable_latch)
    else $error("latch still set after operation end");
  a_end_sets_ready:
    assert property ($fell(write_in_progress) |-> flag_status[7])
    else $error("ready flag low after operation end");
  a_write_while_busy:
    assert property (mem_wr |-> write_in_progress)
    else $error("array write outside an operation");
  a_timeout_stops:
    assert property (op_timeout && write_in_progress |-> ##[1:4] done_s)
    else $error("timeout did not end the operation");
  a_erase_kind_legal:
    assert property (erase_start |-> erase_kind != 2'h1)
    else $error("erase kind code not defined");
  a_erase_goes_busy:
    assert property (erase_start |-> ##[0:4] busy_s)
    else $error("erase start without busy state");
  a_refusal_keeps:
    assert property ($rose(flag_status[1]) |-> write_enable_latch && !write_in_progress
      && (flag_status[4] || flag_status[5]))
    else $error("protection refusal state wrong");
  a_start_needs_latch:
    assert property ($rose(write_in_progress) && !$past(flag_status[2])
      && !$past(flag_status[6]) |-> $past(write_enable_latch))
    else $error("operation started without latch");
endmodule // nor_seq_checker

bind nor_program_erase_sequencer nor_seq_checker chk (
  .clk(clk), .rst(rst), .op_timeout(op_timeout), .write_in_progress(write_in_progress),
  .write_enable_latch(write_enable_latch), .flag_status(flag_status), .mem_wr(mem_wr),
  .erase_start(erase_start), .erase_kind(erase_kind)
);

/* File: verif/spi_host_model.sv */
// ==========================================
// Host side of the serial link
module spi_host_model (
  input  wire logic       clk,
  output logic            sel_n,
  output logic            sclk,
  output logic      [3:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    lines = 4'h5;
  end
  // No pull on the data lines: idle lanes toggle so a stale bit never reads as good
  always @(posedge clk) begin
    if (sel_n)
      lines <= ~lines;
  end
  // Half of the 800 ns link clock period
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic open_frame();
    sel_n = 1'b0;
    half();
  endtask
  // MSB first, changed while the link clock is low
  task automatic shift(input logic [31:0] v, input int nbits, input int lanes);
    logic [3:0] mask;
    mask = 4'((1 << lanes) - 1);
    for (int i = nbits - lanes; i >= 0; i -= lanes) begin
      lines = (~lines & ~mask) | (4'(v >> i) & mask);
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
  endtask
  task automatic close_frame();
    half();
    sel_n = 1'b1;
    half();
  endtask
endmodule // spi_host_model

/* File: verif/nor_program_erase_sequencer_tb_top.sv */
module nor_program_erase_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PP = 600;
  localparam int SE = 300;
  logic        clk = 1'b0, rst = 1'b1, set_write_enable = 1'b0, clear_flags = 1'b0;
  logic        target_protected = 1'b0, any_sector_locked = 1'b0, op_timeout = 1'b0;
  logic        sel_n, sclk, write_in_progress, write_enable_latch, mem_wr, erase_start;
  logic [3:0]  serial_data_lines;
  logic [7:0]  flag_status, mem_wdata, mem_rdata;
  logic [23:0] mem_addr, erase_base, seen_base;
  logic [1:0]  erase_kind, seen_kind;
  logic [7:0]  mem [256], old [256], last [256];
  logic [7:0]  pop [5] = '{8'h02, 8'ha2, 8'hd2, 8'h32, 8'h38};
  logic [7:0]  eop [5] = '{8'h52, 8'h20, 8'hd8, 8'hc7, 8'h60};
  int          pal [5] = '{1, 1, 2, 1, 4};
  int          pdl [5] = '{1, 2, 2, 4, 4};
  int          edur [5] = '{50, 50, SE, 70, 70};
  logic [1:0]  ekind [5] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h0};
  int          failures = 0, total_checks = 0, starts = 0;
  initial forever #50 clk = ~clk;
  nor_program_erase_sequencer #(.PP_CYCLES(PP), .SSE_CYCLES(50), .SE_CYCLES(SE),
    .BE_CYCLES(70)) dut (.clk, .rst, .sel_n, .sclk, .serial_data_lines, .set_write_enable,
    .clear_flags, .target_protected, .any_sector_locked, .op_timeout, .write_in_progress,
    .write_enable_latch, .flag_status, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata,
    .erase_start, .erase_kind, .erase_base);
  spi_host_model host (.clk(clk), .sel_n(sel_n), .sclk(sclk), .lines(serial_data_lines));
  // ==========================================
  // Page of the array and erase start log
  assign mem_rdata = mem[mem_addr[7:0]];
  always @(posedge clk) begin
    if (mem_wr)
      mem[mem_addr[7:0]] <= mem_wdata;
    if (erase_start) begin
      starts    <= starts + 1;
      seen_kind <= erase_kind;
      seen_base <= erase_base;
    end
  end
  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  function automatic logic [7:0] pat(input logic [7:0] s, input int k);
    return 8'(s + k * 59);
  endfunction
  // Fresh page contents; the expected page is old AND the last byte sent per slot
  task automatic prep();
    foreach (old[i]) begin
      old[i]  = 8'(i * 13) ^ 8'ha7;
      mem[i]  = old[i];
      last[i] = 8'hff;
    end
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int an, al, dl, n,
                      input logic [7:0] seed, input int tail = 0);
    host.open_frame();
    host.shift(op, 8, 1);
    host.shift(a, an, al);
    for (int k = 0; k < n; k++) begin
      host.shift(pat(seed, k), 8, dl);
      last[8'(a[7:0] + k)] = pat(seed, k);
    end
    host.shift(8'h15, tail, 1);
    host.close_frame();
  endtask
  task automatic run_op(input int dur);
    int n, cnt;
    n   = 0;
    cnt = 0;
    while (write_in_progress !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    while (write_in_progress === 1'b1 && cnt < dur + 50) begin
      tick();
      cnt++;
    end
    check("busy length in range", 1, cnt >= dur - 2 && cnt <= dur + 4);
  endtask
  task automatic expect_page();
    foreach (mem[i])
      check("page byte", old[i] & last[i], mem[i]);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    $display("mismatch watchdog expected done seen hang");
    give_verdict();
  end
  initial begin
    tick(16);
    rst = 1'b0;
    tick(4);
    check("flags after reset", 8'h80, flag_status);
    for (int j = 0; j < 5; j++) begin
      prep();
      pulse(set_write_enable);
      send(pop[j], 24'h1234fe, 24, pal[j], pdl[j], 3, 8'(j * 40));
      run_op(PP);
      check("latch after program", 0, write_enable_latch);
      expect_page();
      $display("test program %h done", pop[j]);
    end
    prep();
    pulse(set_write_enable);
    send(8'h38, 24'h000000, 24, 4, 4, 258, 8'h11);
    run_op(PP);
    expect_page();
    $display("test overflow done");
    prep();
    send(8'h02, 24'h000010, 24, 1, 1, 1, 8'h00);
    tick(12);
    check("busy without latch", 0, write_in_progress);
    pulse(set_write_enable);
    send(8'h02, 24'h000020, 24, 1, 1, 1, 8'h00, 5);
    tick(12);
    foreach (last[i]) last[i] = 8'hff;
    expect_page();
    check("latch after cut frame", 1, write_enable_latch);
    check("flags after cut frame", 8'h80, flag_status);
    target_protected = 1'b1;
    send(8'h02, 24'h000030, 24, 1, 1, 1, 8'h00);
    tick(12);
    check("flags protected program", 8'h92, flag_status);
    pulse(clear_flags);
    send(8'h20, 24'h000040, 24, 1, 1, 0, 8'h00);
    tick(12);
    check("flags protected erase", 8'ha2, flag_status);
    pulse(clear_flags);
    target_protected  = 1'b0;
    any_sector_locked = 1'b1;
    send(8'hc7, 24'h0, 0, 1, 1, 0, 8'h00);
    tick(12);
    check("flags locked bulk", 8'ha2, flag_status);
    check("latch after refusals", 1, write_enable_latch);
    check("erase starts refused", 0, starts);
    pulse(clear_flags);
    any_sector_locked = 1'b0;
    $display("test refusals done");
    for (int j = 0; j < 5; j++) begin
      pulse(set_write_enable);
      send(eop[j], 24'h345678, j < 3 ? 24 : 0, 1, 1, 0, 8'h00);
      run_op(edur[j]);
      check("erase start count", j + 1, starts);
      check("erase kind", ekind[j], seen_kind);
      if (j < 3)
        check("erase base", j < 2 ? 24'h345000 : 24'h340000, seen_base);
      check("latch after erase", 0, write_enable_latch);
      check("flags after erase", 8'h80, flag_status);
    end
    send(8'h52, 24'h345678, 24, 1, 1, 0, 8'h00);
    tick(12);
    check("erase without latch", 5, starts);
    check("flags without latch", 8'h80, flag_status);
    $display("test erase done");
    pulse(set_write_enable);
    send(8'hd8, 24'h010000, 24, 1, 1, 0, 8'h00);
    tick(8);
    pulse(op_timeout);
    tick(4);
    check("erase timeout state", 3'h1, {write_in_progress, write_enable_latch, flag_status[5]});
    pulse(clear_flags);
    pulse(set_write_enable);
    send(8'h02, 24'h000050, 24, 1, 1, 1, 8'h00);
    tick(8);
    pulse(op_timeout);
    tick(4);
    check("program timeout state", 3'h1, {write_in_progress, write_enable_latch, flag_status[4]});
    pulse(clear_flags);
    $display("test timeout done");
    prep();
    pulse(set_write_enable);
    send(8'h02, 24'h000060, 24, 1, 1, 2, 8'h33);
    tick(8);
    send(8'h75, 24'h0, 0, 1, 1, 0, 8'h00);
    tick(8);
    check("suspend flag", 1, flag_status[2]);
    send(8'h7a, 24'h0, 0, 1, 1, 0, 8'h00);
    tick(8);
    // Suspend lands 84 cycles in; the bench looks again 9 cycles after the resume
    run_op(PP - 93);
    check("resumed program end", 2'h0, {write_in_progress, flag_status[2]});
    expect_page();
    pulse(set_write_enable);
    send(8'hd8, 24'h020000, 24, 1, 1, 0, 8'h00);
    tick(8);
    send(8'h75, 24'h0, 0, 1, 1, 0, 8'h00);
    tick(8);
    check("erase suspend flags", 2'h3, {flag_status[6], flag_status[7]});
    send(8'h7a, 24'h0, 0, 1, 1, 0, 8'h00);
    tick(8);
    run_op(SE - 93);
    check("resumed erase end", 2'h0, {write_in_progress, flag_status[6]});
    $display("test suspend done");
    give_verdict();
  end
endmodule // nor_program_erase_sequencer_tb_top
